/* File: core/phw_defines.svh */
// Shared constants for the PHY host interface and wake logic.
// Assumes inclusion by bare name from the core/ folder.
`ifndef PHW_DEFINES_SVH
`define PHW_DEFINES_SVH
`define PHW_MODE_MII 2'b00
`define PHW_MODE_RMII 2'b01
`define PHW_MODE_REV 2'b11
`define PHW_SRC_INT 2'b00
`define PHW_SRC_OSC 2'b01
`define PHW_SRC_PASS 2'b10
`define PHW_CLK_MHZ 50
`define PHW_MII_CLK_MHZ 25
`define PHW_MII_HALF (`PHW_CLK_MHZ / (2 * `PHW_MII_CLK_MHZ))
`define PHW_WAKE_PULSE_NS 1000
`define PHW_WAKE_PULSE_CYC ((`PHW_WAKE_PULSE_NS * `PHW_CLK_MHZ + 999) / 1000)
`define PHW_MII_PIECES 3'd2
`define PHW_RMII_PIECES 3'd4
`define PHW_ADR_CTRL 4'h0
`define PHW_ADR_TXDATA 4'h4
`define PHW_ADR_RXDATA 4'h8
`define PHW_CTRL_RESET 3'h0
`define PHW_CTRL_DRIVE_BIT 2
`define PHW_RX_VALID_BIT 8
`define PHW_RX_BUSY_BIT 9
`endif

/* File: core/phw_pkg.sv */
// Types shared by both ends and the wake port.
// Assumes nothing beyond a SystemVerilog compiler.
package phw_pkg;
    typedef struct packed {
        logic forward_to_ports_en;
        logic local_wake_accept;
        logic forward_to_cable_en;
        logic remote_wake_accept;
    } phw_wake_cfg_t;
    typedef enum logic [1:0] {PHW_TX_IDLE, PHW_TX_SHIFT} phw_tx_state_t;
    typedef enum logic [1:0] {PHW_WK_ASLEEP, PHW_WK_AWAKE} phw_wake_state_t;
endpackage

/* File: core/phw_mii_if.sv */
// MII / RMII host-interface wires between PHY end and MAC end.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface phw_mii_if;
    logic txc_dev;
    logic txc_dev_oe;
    logic txc_host;
    logic txc_host_oe;
    logic rxc_dev;
    logic rxc_dev_oe;
    logic rxc_host;
    logic rxc_host_oe;
    logic ref_dev;
    logic ref_dev_oe;
    logic ref_host;
    logic ref_host_oe;
    logic txc;
    logic rxc;
    logic ref_clk;
    logic tx_en;
    logic [3:0] txd;
    logic rx_dv;
    logic [3:0] rxd;
    // Undriven clock lines read low
    assign txc = txc_dev_oe ? txc_dev : (txc_host_oe & txc_host);
    assign rxc = rxc_dev_oe ? rxc_dev : (rxc_host_oe & rxc_host);
    assign ref_clk = ref_dev_oe ? ref_dev : (ref_host_oe & ref_host);
    modport dev (output txc_dev, txc_dev_oe, rxc_dev, rxc_dev_oe, ref_dev, ref_dev_oe,
        rx_dv, rxd, input txc, rxc, ref_clk, tx_en, txd);
    modport host (output txc_host, txc_host_oe, rxc_host, rxc_host_oe, ref_host,
        ref_host_oe, tx_en, txd, input txc, rxc, ref_clk, rx_dv, rxd);
endinterface // phw_mii_if

/* File: core/phw_wake_port.sv */
// Per-port sleep state and wake forwarding decisions.
// Assumes single-cycle event pulses from the PHY top.
`timescale 1ns/1ns
`include "phw_defines.svh"
module phw_wake_port #(
    parameter int PULSE_CYC = `PHW_WAKE_PULSE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic sleep_req_i,
    input wire logic remote_wake_i,
    input wire logic local_evt_i,
    input wire logic link_active_i,
    input wire phw_pkg::phw_wake_cfg_t cfg_i,
    output logic awake_o,
    output logic wake_pulse_o,
    output logic wake_request_codes_o,
    output logic fwd_o
);
    import phw_pkg::*;
    localparam int CW = $clog2(PULSE_CYC + 1);
    if (PULSE_CYC < 1) begin : g_chk
        $error("wake pulse must last at least one cycle");
    end
    phw_wake_state_t st_reg;
    logic [CW-1:0] pulse_cnt_reg;
    logic remote_ok;
    logic local_ok;
    logic cable_fwd;
    assign remote_ok = enable_i & remote_wake_i & cfg_i.remote_wake_accept;
    assign local_ok = enable_i & local_evt_i & cfg_i.local_wake_accept;
    assign cable_fwd = enable_i & local_evt_i & cfg_i.forward_to_cable_en;
    assign awake_o = (st_reg == PHW_WK_AWAKE);
    assign wake_pulse_o = (pulse_cnt_reg != '0);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= PHW_WK_ASLEEP;
        end else begin
            case (st_reg)
                PHW_WK_ASLEEP: begin
                    if (remote_ok | local_ok) begin
                        st_reg <= PHW_WK_AWAKE;
                    end
                end
                PHW_WK_AWAKE: begin
                    // Wake wins over a sleep request in the same cycle
                    if (~enable_i | (sleep_req_i & ~remote_ok & ~local_ok)) begin
                        st_reg <= PHW_WK_ASLEEP;
                    end
                end
                default: st_reg <= PHW_WK_ASLEEP;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_cnt_reg <= '0;
        end else if (cable_fwd & ~link_active_i) begin
            pulse_cnt_reg <= CW'(PULSE_CYC);
        end else if (pulse_cnt_reg != '0) begin
            pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_request_codes_o <= 1'b0;
        end else begin
            wake_request_codes_o <= cable_fwd & link_active_i;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fwd_o <= 1'b0;
        end else begin
            fwd_o <= remote_ok & cfg_i.forward_to_ports_en;
        end
    end
endmodule // phw_wake_port

/* File: core/phw_phy_dev.sv */
// PHY end: host-interface modes, clocking, repeater routing, wake logic.
// Assumes the MAC end shares clk_i; wake line and clock-pass are pins.
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "phw_defines.svh"
module phw_phy_dev #(
    parameter int TIMEOUT_W = 16,
    parameter int PULSE_CYC = `PHW_WAKE_PULSE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    phw_mii_if.dev mii,
    input wire logic [1:0] strap_mode_i,
    input wire logic mgmt_mode_wr_i,
    input wire logic [1:0] mgmt_mode_i,
    input wire logic [1:0] ref_src_i,
    input wire logic clk_pass_i,
    input wire logic int_b2b_i,
    input wire logic single_port_i,
    output logic [3:0] tx_data_o,
    output logic line_tx_valid_o,
    output logic peer_tx_valid_o,
    input wire logic [3:0] line_rx_data_i,
    input wire logic line_rx_valid_i,
    input wire logic [3:0] peer_rx_data_i,
    input wire logic peer_rx_valid_i,
    output logic rx_ready_o,
    input wire phw_pkg::phw_wake_cfg_t [1:0] wake_cfg_i,
    input wire logic [1:0] sleep_req_i,
    input wire logic [1:0] remote_wake_i,
    input wire logic [1:0] link_active_i,
    input wire logic [TIMEOUT_W-1:0] wake_timeout_i,
    input wire logic wake_line_i,
    output logic wake_line_o,
    output logic wake_line_oe_o,
    output logic [1:0] wake_pulse_o,
    output logic [1:0] wake_request_codes_o,
    output logic [1:0] port_awake_o,
    output logic regulator_inhibit_out_o,
    output logic [1:0] mode_o
);
    import phw_pkg::*;
    localparam int HALF = `PHW_MII_HALF;
    localparam int DW = $clog2(HALF + 1);
    if (HALF < 1 || TIMEOUT_W < 1) begin : g_chk
        $error("clock divider or timeout width not servable");
    end
    logic strap_done_reg;
    logic [DW-1:0] div_reg;
    logic clk_tgl_reg;
    logic pass_s1_reg;
    logic pass_s2_reg;
    logic txc_prev_reg;
    logic rxc_prev_reg;
    logic ref_prev_reg;
    logic [1:0] tx_part_reg;
    logic tx_half_reg;
    logic [3:0] hold_reg;
    logic hold_full_reg;
    logic rx_half_reg;
    logic [1:0] hi_dibit_reg;
    logic wk_s1_reg;
    logic wk_s2_reg;
    logic wk_s3_reg;
    logic [TIMEOUT_W-1:0] wk_cnt_reg;
    logic rmii;
    logic rev;
    logic tx_beat;
    logic rx_beat;
    logic consume;
    logic accept;
    logic full_next;
    logic src_valid;
    logic [3:0] src_data;
    logic wk_rise;
    logic [1:0] port_en;
    logic [1:0] awake;
    logic [1:0] pulse;
    logic [1:0] codes;
    logic [1:0] fwd;
    assign rmii = (mode_o == `PHW_MODE_RMII);
    assign rev = (mode_o == `PHW_MODE_REV);
    assign tx_beat = rmii ? (mii.ref_clk ^ ref_prev_reg) : (mii.txc & ~txc_prev_reg);
    assign rx_beat = rmii ? (mii.ref_clk ^ ref_prev_reg) : (mii.rxc & ~rxc_prev_reg);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_o <= `PHW_MODE_MII;
            strap_done_reg <= 1'b0;
        end else if (mgmt_mode_wr_i) begin
            mode_o <= mgmt_mode_i;
            strap_done_reg <= 1'b1;
        end else if (!strap_done_reg) begin
            mode_o <= strap_mode_i;
            strap_done_reg <= 1'b1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg <= '0;
            clk_tgl_reg <= 1'b0;
        end else if (div_reg == DW'(HALF - 1)) begin
            div_reg <= '0;
            clk_tgl_reg <= ~clk_tgl_reg;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end
    // Clock-pass pin comes from another device
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pass_s1_reg <= 1'b0;
            pass_s2_reg <= 1'b0;
        end else begin
            pass_s1_reg <= clk_pass_i;
            pass_s2_reg <= pass_s1_reg;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mii.txc_dev <= 1'b0;
            mii.rxc_dev <= 1'b0;
            mii.txc_dev_oe <= 1'b0;
            mii.rxc_dev_oe <= 1'b0;
        end else begin
            mii.txc_dev <= clk_tgl_reg;
            mii.rxc_dev <= clk_tgl_reg;
            mii.txc_dev_oe <= ~rev & ~rmii;
            mii.rxc_dev_oe <= ~rev & ~rmii;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mii.ref_dev <= 1'b0;
            mii.ref_dev_oe <= 1'b0;
        end else begin
            mii.ref_dev <= (ref_src_i == `PHW_SRC_PASS) ? pass_s2_reg : ~mii.ref_dev;
            mii.ref_dev_oe <= rmii & (ref_src_i != `PHW_SRC_OSC);
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txc_prev_reg <= 1'b0;
            rxc_prev_reg <= 1'b0;
            ref_prev_reg <= 1'b0;
        end else begin
            txc_prev_reg <= mii.txc;
            rxc_prev_reg <= mii.rxc;
            ref_prev_reg <= mii.ref_clk;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_part_reg <= 2'b00;
            tx_half_reg <= 1'b0;
            tx_data_o <= 4'h0;
            line_tx_valid_o <= 1'b0;
            peer_tx_valid_o <= 1'b0;
        end else begin
            line_tx_valid_o <= 1'b0;
            peer_tx_valid_o <= 1'b0;
            if (tx_beat & mii.tx_en) begin
                if (!rmii) begin
                    tx_data_o <= mii.txd;
                    line_tx_valid_o <= ~int_b2b_i;
                    peer_tx_valid_o <= int_b2b_i;
                end else if (!tx_half_reg) begin
                    tx_part_reg <= mii.txd[1:0];
                    tx_half_reg <= 1'b1;
                end else begin
                    tx_data_o <= {mii.txd[1:0], tx_part_reg};
                    line_tx_valid_o <= ~int_b2b_i;
                    peer_tx_valid_o <= int_b2b_i;
                    tx_half_reg <= 1'b0;
                end
            end else if (tx_beat) begin
                tx_half_reg <= 1'b0;
            end
        end
    end
    assign src_valid = int_b2b_i ? peer_rx_valid_i : line_rx_valid_i;
    assign src_data = int_b2b_i ? peer_rx_data_i : line_rx_data_i;
    assign accept = src_valid & rx_ready_o;
    // High dibit is parked, so the slot frees a beat early and RMII has no gaps
    assign consume = rx_beat & hold_full_reg & ~(rmii & rx_half_reg);
    assign full_next = (hold_full_reg & ~consume) | accept;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_reg <= 4'h0;
            hold_full_reg <= 1'b0;
            rx_ready_o <= 1'b0;
        end else begin
            if (accept) begin
                hold_reg <= src_data;
            end
            hold_full_reg <= full_next;
            rx_ready_o <= ~full_next;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mii.rx_dv <= 1'b0;
            mii.rxd <= 4'h0;
            rx_half_reg <= 1'b0;
            hi_dibit_reg <= 2'b00;
        end else if (rx_beat) begin
            mii.rx_dv <= hold_full_reg | (rmii & rx_half_reg);
            rx_half_reg <= 1'b0;
            if (rmii & rx_half_reg) begin
                mii.rxd <= {2'b00, hi_dibit_reg};
            end else if (hold_full_reg & !rmii) begin
                mii.rxd <= hold_reg;
            end else if (hold_full_reg) begin
                mii.rxd <= {2'b00, hold_reg[1:0]};
                hi_dibit_reg <= hold_reg[3:2];
                rx_half_reg <= 1'b1;
            end
        end
    end
    assign port_en = {~single_port_i, 1'b1};
    assign wk_rise = wk_s2_reg & ~wk_s3_reg & ~wake_line_oe_o;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wk_s1_reg <= 1'b0;
            wk_s2_reg <= 1'b0;
            wk_s3_reg <= 1'b0;
        end else begin
            wk_s1_reg <= wake_line_i;
            wk_s2_reg <= wk_s1_reg;
            wk_s3_reg <= wk_s2_reg;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wk_cnt_reg <= '0;
            wake_line_o <= 1'b0;
            wake_line_oe_o <= 1'b0;
        end else begin
            if (|fwd) begin
                wk_cnt_reg <= wake_timeout_i;
            end else if (wk_cnt_reg != '0) begin
                wk_cnt_reg <= wk_cnt_reg - 1'b1;
            end
            wake_line_o <= (|fwd) | (wk_cnt_reg > 1);
            wake_line_oe_o <= (|fwd) | (wk_cnt_reg > 1);
        end
    end
    for (genvar p = 0; p < 2; p++) begin : g_port
        phw_wake_port #(
            .PULSE_CYC(PULSE_CYC)
        ) u_wake (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .enable_i(port_en[p]),
            .sleep_req_i(sleep_req_i[p]),
            .remote_wake_i(remote_wake_i[p]),
            .local_evt_i(wk_rise | fwd[1-p]),
            .link_active_i(link_active_i[p]),
            .cfg_i(wake_cfg_i[p]),
            .awake_o(awake[p]),
            .wake_pulse_o(pulse[p]),
            .wake_request_codes_o(codes[p]),
            .fwd_o(fwd[p])
        );
    end
    // inhibit follows sleep of all enabled ports
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            regulator_inhibit_out_o <= 1'b1;
            port_awake_o <= 2'b00;
            wake_pulse_o <= 2'b00;
            wake_request_codes_o <= 2'b00;
        end else begin
            regulator_inhibit_out_o <= |(awake & port_en);
            port_awake_o <= awake;
            wake_pulse_o <= pulse;
            wake_request_codes_o <= codes;
        end
    end
endmodule // phw_phy_dev

/* File: core/phw_mac_host.sv */
// MAC end: byte transmit and receive over MII/RMII, Wishbone registers.
// Assumes the PHY end shares clk_i and is set to the same mode.
`timescale 1ns/1ns
`include "phw_defines.svh"
module phw_mac_host (
    input wire logic clk_i,
    input wire logic rst_i,
    phw_mii_if.host mii,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    import phw_pkg::*;
    logic [2:0] ctrl_reg;
    phw_tx_state_t tx_st_reg;
    logic [7:0] tx_sh_reg;
    logic [2:0] tx_cnt_reg;
    logic [7:0] rx_acc_reg;
    logic [2:0] rx_cnt_reg;
    logic [7:0] rx_byte_reg;
    logic rx_valid_reg;
    logic txc_prev_reg;
    logic rxc_prev_reg;
    logic ref_prev_reg;
    logic rmii;
    logic drive;
    logic tx_beat;
    logic rx_beat;
    logic req;
    logic commit;
    logic tx_load;
    logic rx_done;
    logic [2:0] pieces;
    assign rmii = (ctrl_reg[1:0] == `PHW_MODE_RMII);
    assign drive = ctrl_reg[`PHW_CTRL_DRIVE_BIT];
    assign pieces = rmii ? `PHW_RMII_PIECES : `PHW_MII_PIECES;
    assign tx_beat = rmii ? (mii.ref_clk ^ ref_prev_reg) : (mii.txc & ~txc_prev_reg);
    assign rx_beat = rmii ? (mii.ref_clk ^ ref_prev_reg) : (mii.rxc & ~rxc_prev_reg);
    // Byte writes stall while a byte is still shifting out
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o &
        ~(wb_we_i & (wb_adr_i == `PHW_ADR_TXDATA) & (tx_st_reg != PHW_TX_IDLE));
    assign commit = wb_cyc_i & wb_stb_i & wb_ack_o;
    assign tx_load = commit & wb_we_i & (wb_adr_i == `PHW_ADR_TXDATA) & wb_sel_i[0];
    assign rx_done = rx_beat & mii.rx_dv & (rx_cnt_reg == pieces - 3'd1);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req;
            if (req) begin
                case (wb_adr_i)
                    `PHW_ADR_CTRL: wb_dat_o <= {29'h0, ctrl_reg};
                    `PHW_ADR_RXDATA: wb_dat_o <= {22'h0, tx_st_reg != PHW_TX_IDLE,
                        rx_valid_reg, rx_byte_reg};
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end
    // mode and clock drive match the PHY
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `PHW_CTRL_RESET;
        end else if (commit & wb_we_i & (wb_adr_i == `PHW_ADR_CTRL) & wb_sel_i[0]) begin
            ctrl_reg <= wb_dat_i[2:0];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mii.txc_host <= 1'b0;
            mii.rxc_host <= 1'b0;
            mii.ref_host <= 1'b0;
            mii.txc_host_oe <= 1'b0;
            mii.rxc_host_oe <= 1'b0;
            mii.ref_host_oe <= 1'b0;
        end else begin
            mii.txc_host <= ~mii.txc_host;
            mii.rxc_host <= ~mii.txc_host;
            mii.ref_host <= ~mii.ref_host;
            mii.txc_host_oe <= drive & (ctrl_reg[1:0] == `PHW_MODE_REV);
            mii.rxc_host_oe <= drive & (ctrl_reg[1:0] == `PHW_MODE_REV);
            mii.ref_host_oe <= drive & rmii;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txc_prev_reg <= 1'b0;
            rxc_prev_reg <= 1'b0;
            ref_prev_reg <= 1'b0;
        end else begin
            txc_prev_reg <= mii.txc;
            rxc_prev_reg <= mii.rxc;
            ref_prev_reg <= mii.ref_clk;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_st_reg <= PHW_TX_IDLE;
            tx_sh_reg <= 8'h0;
            tx_cnt_reg <= 3'd0;
            mii.tx_en <= 1'b0;
            mii.txd <= 4'h0;
        end else begin
            case (tx_st_reg)
                PHW_TX_IDLE: begin
                    if (tx_load) begin
                        tx_sh_reg <= wb_dat_i[7:0];
                        tx_cnt_reg <= pieces;
                        tx_st_reg <= PHW_TX_SHIFT;
                    end else if (tx_beat) begin
                        mii.tx_en <= 1'b0;
                    end
                end
                PHW_TX_SHIFT: begin
                    if (tx_beat) begin
                        mii.tx_en <= 1'b1;
                        mii.txd <= rmii ? {2'b00, tx_sh_reg[1:0]} : tx_sh_reg[3:0];
                        tx_sh_reg <= rmii ? {2'b00, tx_sh_reg[7:2]} : {4'h0, tx_sh_reg[7:4]};
                        tx_cnt_reg <= tx_cnt_reg - 3'd1;
                        if (tx_cnt_reg == 3'd1) begin
                            tx_st_reg <= PHW_TX_IDLE;
                        end
                    end
                end
                default: tx_st_reg <= PHW_TX_IDLE;
            endcase
        end
    end
    // receive assembly, valid set wins over read clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_acc_reg <= 8'h0;
            rx_cnt_reg <= 3'd0;
            rx_byte_reg <= 8'h0;
            rx_valid_reg <= 1'b0;
        end else begin
            if (rx_beat & mii.rx_dv) begin
                rx_acc_reg <= rmii ? {mii.rxd[1:0], rx_acc_reg[7:2]} : {mii.rxd, rx_acc_reg[7:4]};
                rx_cnt_reg <= rx_done ? 3'd0 : rx_cnt_reg + 3'd1;
            end else if (rx_beat) begin
                rx_cnt_reg <= 3'd0;
            end
            if (rx_done) begin
                rx_byte_reg <= rmii ? {mii.rxd[1:0], rx_acc_reg[7:2]} : {mii.rxd, rx_acc_reg[7:4]};
                rx_valid_reg <= 1'b1;
            end else if (commit & ~wb_we_i & (wb_adr_i == `PHW_ADR_RXDATA)) begin
                rx_valid_reg <= 1'b0;
            end
        end
    end
endmodule // phw_mac_host

/* File: verification/phw_link_asserts.sv */
// Checker on the wires between PHY end and MAC end.
// Assumes instantiation beside the interface, sharing clk_i and rst_i.
`timescale 1ns/1ns
module phw_link_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic txc,
    input wire logic rxc,
    input wire logic ref_clk,
    input wire logic txc_dev_oe,
    input wire logic rxc_dev_oe,
    input wire logic txc_host_oe,
    input wire logic ref_dev_oe,
    input wire logic [3:0] txd,
    input wire logic [3:0] rxd
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_txc_toggles: assert property (txc_dev_oe && $past(txc_dev_oe) |-> txc != $past(txc))
        else $error("txc stalled");
    chk_rxc_toggles: assert property (rxc_dev_oe && $past(rxc_dev_oe) |-> rxc != $past(rxc))
        else $error("rxc stalled");
    // Clock-pass source moves only every second cycle
    chk_ref_toggles: assert property (ref_dev_oe && $past(ref_dev_oe, 2) |->
        $changed(ref_clk) || $past(ref_clk) != $past(ref_clk, 2))
        else $error("ref stalled");
    chk_one_driver: assert property (!(txc_dev_oe && txc_host_oe))
        else $error("txc driven twice");
    chk_rev_inputs: assert property (txc_host_oe |-> !txc_dev_oe && !rxc_dev_oe)
        else $error("clock not input");
    chk_mode_excl: assert property (!(txc_dev_oe && ref_dev_oe))
        else $error("two modes");
    chk_rmii_pairs: assert property ($past(ref_dev_oe) && $changed(rxd) |-> rxd[3:2] == 2'h0)
        else $error("rmii upper bits");
    // Launch only just after a txc rise
    chk_txd_on_beat: assert property (txc_dev_oe && $changed(txd) |-> $past(txc) && !$past(txc, 2))
        else $error("txd off beat");
endmodule // phw_link_asserts

/* File: verification/testbench.sv */
// Bench joining PHY end and MAC end through the host interface.
// Assumes the core/ files are compiled first.
`timescale 1ns/1ns
module testbench;
    import phw_pkg::*;
    logic clk_i = 0, rst_i = 1, mgmt_mode_wr_i = 0, clk_pass_i = 0, int_b2b_i = 0;
    logic single_port_i = 0, line_rx_valid_i = 0, peer_rx_valid_i = 0, wake_line_i = 0;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, line_tx_valid_o, peer_tx_valid_o;
    logic rx_ready_o, wake_line_o, wake_line_oe_o, regulator_inhibit_out_o;
    logic [1:0] strap_mode_i = 0, mgmt_mode_i = 0, ref_src_i = 0, sleep_req_i = 0, mode_o;
    logic [1:0] remote_wake_i = 0, link_active_i = 0, wake_pulse_o, wake_request_codes_o;
    logic [1:0] port_awake_o;
    logic [3:0] tx_data_o, line_rx_data_i = 0, peer_rx_data_i = 0, wb_adr_i = 0, wb_sel_i = 4'hf;
    logic [15:0] wake_timeout_i = 16'h28;
    logic [31:0] wb_dat_i = 0, wb_dat_o, q;
    phw_wake_cfg_t [1:0] wake_cfg_i = 8'h69;
    logic [3:0] nq[$];
    int error_cnt = 0, comparisons = 0;
    phw_mii_if mii();
    phw_phy_dev #(.PULSE_CYC(20)) phw_phy_dev_inst (.*);
    phw_mac_host phw_mac_host_inst (.*);
    phw_link_asserts phw_link_asserts_inst (.clk_i(clk_i), .rst_i(rst_i), .txc(mii.txc),
        .rxc(mii.rxc), .ref_clk(mii.ref_clk), .txc_dev_oe(mii.txc_dev_oe),
        .rxc_dev_oe(mii.rxc_dev_oe), .txc_host_oe(mii.txc_host_oe),
        .ref_dev_oe(mii.ref_dev_oe), .txd(mii.txd), .rxd(mii.rxd));
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i)
        if ((int_b2b_i ? peer_tx_valid_o : line_tx_valid_o) === 1'b1)
            nq.push_back(tx_data_o);
    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %0t saw %h want %h", $time, s, e);
        end
    endtask
    // Waits for ack (0) or rx ready (1); running out counts as a mismatch
    task wt(input logic r);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ((r ? rx_ready_o : wb_ack_o) !== 1'b1 && n < 400);
        if ((r ? rx_ready_o : wb_ack_o) !== 1'b1)
            error_cnt++;
    endtask
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wt(0);
        q = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
    endtask
    // Same byte both ways, low nibble first
    task xfer(input logic [7:0] b);
        nq = {};
        wb(1, 4'h4, {24'h0, b});
        // Only the selected source offers data
        {line_rx_valid_i, peer_rx_valid_i} <= int_b2b_i ? 2'h1 : 2'h2;
        for (int k = 0; k < 2; k++) begin
            {line_rx_data_i, peer_rx_data_i} <= {2{b[k*4+:4]}};
            wt(1);
        end
        {line_rx_valid_i, peer_rx_valid_i} <= 2'h0;
        repeat (40) @(posedge clk_i);
        chk({nq[1], nq[0]}, b);
        chk(nq.size(), 2);
        wb(0, 4'h8, 0);
        chk(q, {23'h0, 1'b1, b});
    endtask
    task finish_test;
        if (error_cnt == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        repeat (2) @(posedge clk_i);
        wb(0, 4'hc, 0);
        chk(q, 0);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            mgmt_mode_wr_i <= 1;
            mgmt_mode_i <= (i == 2) ? 2'h3 : i[1:0];
            int_b2b_i <= (i == 2);
            @(posedge clk_i);
            mgmt_mode_wr_i <= 0;
            wb(1, 4'h0, {29'h0, i == 2, mgmt_mode_i});
            chk(mode_o, mgmt_mode_i);
            xfer(8'ha5 + i[7:0]);
        end
        sleep_req_i <= 2'h3;
        repeat (5) @(posedge clk_i);
        remote_wake_i <= 2'h2;
        @(posedge clk_i);
        remote_wake_i <= 0;
        repeat (5) @(posedge clk_i);
        chk({port_awake_o, regulator_inhibit_out_o}, 0);
        sleep_req_i <= 0;
        remote_wake_i <= 2'h1;
        @(posedge clk_i);
        remote_wake_i <= 0;
        repeat (8) @(posedge clk_i);
        chk({port_awake_o, wake_pulse_o, wake_line_o, wake_line_oe_o,
            regulator_inhibit_out_o}, 7'h77);
        sleep_req_i <= 2'h3;
        repeat (40) @(posedge clk_i);
        chk({port_awake_o, wake_line_oe_o, regulator_inhibit_out_o}, 0);
        sleep_req_i <= 0;
        link_active_i <= 2'h2;
        wake_line_i <= 1;
        repeat (5) @(posedge clk_i);
        chk({port_awake_o, wake_request_codes_o, wake_pulse_o,
            regulator_inhibit_out_o}, 7'h51);
        single_port_i <= 1;
        wake_line_i <= 0;
        repeat (3) @(posedge clk_i);
        chk({port_awake_o, regulator_inhibit_out_o}, 0);
        finish_test;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        finish_test;
    end
endmodule // testbench
